// ===== position_complete_pkg.sv
`default_nettype none
// ==========================================================
// Shared constants for the positioning status block
package position_complete_pkg;

  // ========================================================
  // Register offsets on the parameter port
  localparam logic [3:0] OFF_JUDGING_MODE   = 4'h0;
  localparam logic [3:0] OFF_COMPLETION_THR = 4'h1;
  localparam logic [3:0] OFF_NEAR_THR       = 4'h2;
  localparam logic [3:0] OFF_WINDOW_TIME    = 4'h3;
  localparam logic [3:0] OFF_HOLD_TIME      = 4'h4;
  localparam logic [3:0] OFF_OUT1_FUNCTION  = 4'h5;
  localparam logic [3:0] OFF_OUT1_LOGIC     = 4'h6;
  localparam logic [3:0] OFF_STATUS         = 4'h7;

  // ========================================================
  // Reset values
  localparam logic [1:0]  RST_JUDGING_MODE   = 2'h0;
  localparam logic [15:0] RST_COMPLETION_THR = 16'h0320;
  localparam logic [15:0] RST_NEAR_THR       = 16'h1388;
  localparam logic [15:0] RST_WINDOW_TIME    = 16'h000A;
  localparam logic [15:0] RST_HOLD_TIME      = 16'h0064;
  localparam logic [7:0]  RST_OUT1_FUNCTION  = 8'h83;
  localparam logic        RST_OUT1_LOGIC     = 1'h0;

  // ========================================================
  // Judging modes and output function codes
  localparam logic [1:0] MODE_DEVIATION   = 2'h0;
  localparam logic [1:0] MODE_CMD_ZERO    = 2'h1;
  localparam logic [1:0] MODE_FILT_ZERO   = 2'h2;
  localparam logic [1:0] MODE_FILT_WINDOW = 2'h3;
  localparam logic [7:0] FUNC_COMPLETED   = 8'h86;
  localparam logic [7:0] FUNC_NEAR        = 8'h87;

  // ========================================================
  // Status bit positions
  localparam int STAT_COMPLETED = 0;
  localparam int STAT_NEAR      = 1;
  localparam int STAT_OUTPUT    = 2;

  // ========================================================
  // Timing: one millisecond in clock cycles
  localparam int CLK_PERIOD_NS     = 100;
  localparam int MS_NS             = 1000000;
  localparam int MS_CYCLES_DEFAULT = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : position_complete_pkg
`default_nettype wire

// ===== position_complete_output.sv
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Judging mode selects condition sets; modes 2 and 3 share one
// - Mode 0: deviation below completion/near threshold
// - Mode 1: also incoming command zero
// - Mode 2: also filtered command zero
// - Mode 3: filtered zero, persisting through window
// - Completion conditions must hold for window milliseconds
// - Completed output held for hold milliseconds
// - Function 134 completed, 135 near
// - Logic 0: transistor on while valid
// - Logic 1: transistor off while valid
// - Deviation is reference minus feedback, absolute
module position_complete_output
#(
  parameter int MS_CYCLES = position_complete_pkg::MS_CYCLES_DEFAULT
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  input  wire logic [31:0] position_reference,
  input  wire logic [31:0] position_feedback,
  input  wire logic [15:0] position_command,
  input  wire logic [15:0] filtered_command,
  output logic             positioning_completed_status,
  output logic             positioning_near_status,
  output logic             digital_output_one
);

  // ========================================================
  // Settings held by software
  logic [1:0]  judging_mode_setting;
  logic [15:0] completion_threshold;
  logic [15:0] near_threshold;
  logic [15:0] detection_window_time;
  logic [15:0] completion_hold_time;
  logic [7:0]  output1_function_select;
  logic        output1_logic_select;

  // ========================================================
  // Internal condition and timing signals
  logic [31:0] abs_deviation;
  logic        below_completion;
  logic        below_near;
  logic        command_zero;
  logic        filter_zero;
  logic        completion_cond;
  logic        near_cond;
  logic [31:0] window_count;
  logic [31:0] hold_count;
  logic [31:0] window_cycles;
  logic [31:0] hold_cycles;
  logic        window_met;
  logic        selected_valid;

  // ========================================================
  // Helpers

  // Magnitude of a two's complement difference
  function automatic logic [31:0] abs_value(input logic [31:0] value);
    return value[31] ? 32'h0 - value : value;
  endfunction : abs_value

  // Milliseconds to cycles; 20000 ms fits well inside 32 bits
  function automatic logic [31:0] ms_to_cycles(input logic [15:0] ms);
    return 32'(ms) * 32'(MS_CYCLES);
  endfunction : ms_to_cycles

  // Saturating count so a long wait never wraps to zero
  function automatic logic [31:0] count_up(input logic [31:0] value);
    return (value != 32'hFFFFFFFF) ? value + 32'h1 : value;
  endfunction : count_up

  // ========================================================
  // Register writes
  // Writes act at once
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      judging_mode_setting    <= position_complete_pkg::RST_JUDGING_MODE;
      completion_threshold    <= position_complete_pkg::RST_COMPLETION_THR;
      near_threshold          <= position_complete_pkg::RST_NEAR_THR;
      detection_window_time   <= position_complete_pkg::RST_WINDOW_TIME;
      completion_hold_time    <= position_complete_pkg::RST_HOLD_TIME;
      output1_function_select <= position_complete_pkg::RST_OUT1_FUNCTION;
      output1_logic_select    <= position_complete_pkg::RST_OUT1_LOGIC;
    end
    else if (reg_write)
    begin
      if (reg_addr == position_complete_pkg::OFF_JUDGING_MODE)
      begin
        judging_mode_setting <= reg_wdata[1:0];
      end
      else if (reg_addr == position_complete_pkg::OFF_COMPLETION_THR)
      begin
        completion_threshold <= reg_wdata;
      end
      else if (reg_addr == position_complete_pkg::OFF_NEAR_THR)
      begin
        near_threshold <= reg_wdata;
      end
      else if (reg_addr == position_complete_pkg::OFF_WINDOW_TIME)
      begin
        detection_window_time <= reg_wdata;
      end
      else if (reg_addr == position_complete_pkg::OFF_HOLD_TIME)
      begin
        completion_hold_time <= reg_wdata;
      end
      else if (reg_addr == position_complete_pkg::OFF_OUT1_FUNCTION)
      begin
        output1_function_select <= reg_wdata[7:0];
      end
      else if (reg_addr == position_complete_pkg::OFF_OUT1_LOGIC)
      begin
        output1_logic_select <= reg_wdata[0];
      end
    end
  end

  // ========================================================
  // Register reads, data valid in the following cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (!reg_read)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_addr == position_complete_pkg::OFF_JUDGING_MODE)
    begin
      reg_rdata <= {14'h0000, judging_mode_setting};
    end
    else if (reg_addr == position_complete_pkg::OFF_COMPLETION_THR)
    begin
      reg_rdata <= completion_threshold;
    end
    else if (reg_addr == position_complete_pkg::OFF_NEAR_THR)
    begin
      reg_rdata <= near_threshold;
    end
    else if (reg_addr == position_complete_pkg::OFF_WINDOW_TIME)
    begin
      reg_rdata <= detection_window_time;
    end
    else if (reg_addr == position_complete_pkg::OFF_HOLD_TIME)
    begin
      reg_rdata <= completion_hold_time;
    end
    else if (reg_addr == position_complete_pkg::OFF_OUT1_FUNCTION)
    begin
      reg_rdata <= {8'h00, output1_function_select};
    end
    else if (reg_addr == position_complete_pkg::OFF_OUT1_LOGIC)
    begin
      reg_rdata <= {15'h0000, output1_logic_select};
    end
    else if (reg_addr == position_complete_pkg::OFF_STATUS)
    begin
      reg_rdata <= 16'h0000;
      reg_rdata[position_complete_pkg::STAT_COMPLETED] <= positioning_completed_status;
      reg_rdata[position_complete_pkg::STAT_NEAR]      <= positioning_near_status;
      reg_rdata[position_complete_pkg::STAT_OUTPUT]    <= digital_output_one;
    end
    else
    begin
      // Unmapped offsets read as zero
      reg_rdata <= 16'h0000;
    end
  end

  // ========================================================
  // Deviation and threshold comparisons
  // Reference minus feedback
  assign abs_deviation = abs_value(position_reference - position_feedback);

  assign below_completion = abs_deviation < {16'h0000, completion_threshold};
  assign below_near       = abs_deviation < {16'h0000, near_threshold};
  assign command_zero     = position_command == 16'h0000;
  assign filter_zero      = filtered_command == 16'h0000;

  // Condition selection by judging mode
  always_comb
  begin
    completion_cond = 1'h0;
    near_cond       = 1'h0;
    case (judging_mode_setting)
      position_complete_pkg::MODE_DEVIATION:
      begin
        completion_cond = below_completion;
        near_cond       = below_near;
      end
      position_complete_pkg::MODE_CMD_ZERO:
      begin
        completion_cond = below_completion && command_zero;
        near_cond       = below_near && command_zero;
      end
      position_complete_pkg::MODE_FILT_ZERO:
      begin
        completion_cond = below_completion && filter_zero;
        near_cond       = below_near && filter_zero;
      end
      default:
      begin
        completion_cond = below_completion && filter_zero;
        near_cond       = below_near && filter_zero;
      end
    endcase
  end

  // ========================================================
  // Detection window and hold timing
  // Cycle counts track the settings live, so a change lands at once
  assign window_cycles = ms_to_cycles(detection_window_time);
  assign hold_cycles   = ms_to_cycles(completion_hold_time);

  assign window_met = completion_cond && (window_count >= window_cycles);

  // Window counter; any gap in the condition starts it over
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      window_count <= 32'h0;
    end
    else if (!completion_cond)
    begin
      window_count <= 32'h0;
    end
    else
    begin
      window_count <= count_up(window_count);
    end
  end

  // Completed flag with minimum hold
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      positioning_completed_status <= 1'h0;
      hold_count                   <= 32'h0;
    end
    else if (!positioning_completed_status)
    begin
      hold_count <= 32'h0;
      if (window_met)
      begin
        positioning_completed_status <= 1'h1;
      end
    end
    else
    begin
      hold_count <= count_up(hold_count);
      if (!window_met && (hold_count >= hold_cycles))
      begin
        positioning_completed_status <= 1'h0;
      end
    end
  end

  // Near flag follows its condition with no window
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      positioning_near_status <= 1'h0;
    end
    else
    begin
      positioning_near_status <= near_cond;
    end
  end

  // ========================================================
  // Digital output terminal
  // Function code routing
  always_comb
  begin
    selected_valid = 1'h0;
    if (output1_function_select == position_complete_pkg::FUNC_COMPLETED)
    begin
      selected_valid = positioning_completed_status;
    end
    else if (output1_function_select == position_complete_pkg::FUNC_NEAR)
    begin
      selected_valid = positioning_near_status;
    end
  end

  // High drives the output transistor on; other codes stay invalid
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      digital_output_one <= 1'h0;
    end
    else if (!output1_logic_select)
    begin
      digital_output_one <= selected_valid;
    end
    else
    begin
      digital_output_one <= !selected_valid;
    end
  end

endmodule : position_complete_output
`default_nettype wire

// ===== position_complete_output_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port-level checker for the positioning status block
module position_complete_output_props
#(
  parameter int MS_CYCLES = 4
)
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic [31:0] position_reference,
  input wire logic [31:0] position_feedback,
  input wire logic [15:0] position_command,
  input wire logic [15:0] filtered_command,
  input wire logic        positioning_completed_status,
  input wire logic        positioning_near_status,
  input wire logic        digital_output_one
);
  logic [1:0]  mode;
  logic [15:0] cthr, nthr, win, hold;
  logic [7:0]  func;
  logic        lgc, zero, cc, cn, sel;
  logic [31:0] dev, adev, wcnt, hcnt, wlim, hlim;
  // Shadow settings, so limits follow live rewrites
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      mode <= 2'h0;
      cthr <= 16'h0320;
      nthr <= 16'h1388;
      win  <= 16'h000A;
      hold <= 16'h0064;
      func <= 8'h83;
      lgc  <= 1'h0;
    end
    else if (reg_write)
      case (reg_addr)
        4'h0: mode <= reg_wdata[1:0];
        4'h1: cthr <= reg_wdata;
        4'h2: nthr <= reg_wdata;
        4'h3: win  <= reg_wdata;
        4'h4: hold <= reg_wdata;
        4'h5: func <= reg_wdata[7:0];
        4'h6: lgc  <= reg_wdata[0];
        default: ;
      endcase
  // Conditions seen from the pins; wrap difference then magnitude
  assign dev  = position_reference - position_feedback;
  assign adev = dev[31] ? -dev : dev;
  assign zero = (mode == 2'h0) || (mode == 2'h1 ? position_command == 16'h0
                                                : filtered_command == 16'h0);
  assign cc   = zero && (adev < {16'h0, cthr});
  assign cn   = zero && (adev < {16'h0, nthr});
  assign sel  = (func == 8'h86) ? positioning_completed_status
              : (func == 8'h87) && positioning_near_status;
  assign wlim = win * MS_CYCLES;
  assign hlim = hold * MS_CYCLES;
  // Run length of the condition and of the completed level
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      wcnt <= 32'h0;
      hcnt <= 32'h0;
    end
    else
    begin
      wcnt <= cc ? wcnt + 32'h1 : 32'h0;
      hcnt <= positioning_completed_status ? hcnt + 32'h1 : 32'h0;
    end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence stat_rd;
    reg_read && reg_addr == 4'h7;
  endsequence
  sequence ripe;
    cc && wcnt >= wlim;
  endsequence
  stat_read_a: assert property (
    stat_rd |=> reg_rdata == {13'h0, $past(digital_output_one),
      $past(positioning_near_status), $past(positioning_completed_status)})
    else $error("status read mismatch");
  mode_read_a: assert property (
    reg_read && reg_addr == 4'h0 |=> reg_rdata == {14'h0, $past(mode)})
    else $error("mode readback mismatch");
  near_track_a: assert property (
    ##1 positioning_near_status == $past(cn))
    else $error("near status wrong");
  out_pol_a: assert property (
    ##1 digital_output_one == $past(sel ^ lgc))
    else $error("output terminal level wrong");
  win_min_a: assert property (
    $rose(positioning_completed_status) |-> $past(cc) && $past(wcnt) >= $past(wlim))
    else $error("completed before window");
  set_bound_a: assert property (
    ripe |=> positioning_completed_status)
    else $error("completed late");
  comp_release_a: assert property (
    positioning_completed_status && !cc && hcnt >= hlim |=> !positioning_completed_status)
    else $error("completed not released");
  hold_min_a: assert property (
    $fell(positioning_completed_status) |-> $past(hcnt) >= $past(hlim))
    else $error("completed dropped early");
endmodule : position_complete_output_props
bind position_complete_output position_complete_output_props #(.MS_CYCLES(MS_CYCLES)) chk (
  .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .position_reference, .position_feedback, .position_command, .filtered_command,
  .positioning_completed_status, .positioning_near_status, .digital_output_one);
`default_nettype wire

// ===== host_reader.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host controller: watches the output terminal
module host_reader
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       digital_output_one,
  output var  logic [7:0] toggles
);
  logic last;
  // Count level changes the host would see
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      last    <= 1'h0;
      toggles <= 8'h00;
    end
    else
    begin
      last <= digital_output_one;
      if (last != digital_output_one)
        toggles <= toggles + 8'h01;
    end
endmodule : host_reader
`default_nettype wire

// ===== position_complete_output_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench: reads are scored from a queue of notes
module position_complete_output_tb;
  localparam int MS = 4;
  logic        sys_clk, rst_n, reg_write, reg_read, rd_d, lg, z, ec, en;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, position_command, filtered_command, v;
  logic [31:0] position_reference, position_feedback, base, d;
  logic        positioning_completed_status, positioning_near_status, digital_output_one;
  logic [7:0]  toggles, fn;
  logic [15:0] exp_q[$];
  int          miscompares, n_tests, k;
  position_complete_output #(.MS_CYCLES(MS)) uut (.sys_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .position_reference, .position_feedback,
    .position_command, .filtered_command, .positioning_completed_status,
    .positioning_near_status, .digital_output_one);
  host_reader host (.sys_clk, .rst_n, .digital_output_one, .toggles);
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] dat);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= dat;
    reg_write <= 1'h1;
    @(posedge sys_clk);
    reg_write <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] ex);
    exp_q.push_back(ex);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge sys_clk);
    reg_read <= 1'h0;
  endtask : rd
  task automatic wrap_up;
    $display("Compared %0d, mismatched %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk) rd_d <= reg_read;
  always @(negedge sys_clk)
    if (rd_d === 1'h1)
      chk(reg_rdata, exp_q.pop_front());
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    $display("[ERR] %0t run timed out", $time);
    miscompares++;
    wrap_up();
  end
  initial
  begin
    {rst_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {position_command, filtered_command, position_feedback} = '0;
    position_reference = 32'h0010_0000;
    void'($urandom(32'h8315));
    base = $urandom;
    position_feedback = base;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'h1;
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0320);
    rd(4'h2, 16'h1388);
    rd(4'h3, 16'h000A);
    rd(4'h4, 16'h0064);
    rd(4'h5, 16'h0083);
    rd(4'h6, 16'h0000);
    rd(4'h7, 16'h0000);
    $display("Test defaults done");
    v = 16'($urandom);
    wr(4'h2, v);
    rd(4'h2, v);
    wr(4'h0, 16'hFFFF);
    rd(4'h0, 16'h0003);
    wr(4'h2, 16'h1388);
    wr(4'h3, 16'h0001);
    wr(4'h4, 16'h0001);
    $display("Test settings done");
    // Every mode, zero test, code and polarity, both deviation sizes, random sign
    for (k = 0; k < 32; k++)
    begin
      fn = k[2] ? 8'h87 : 8'h86;
      lg = k[3];
      position_reference <= base + 32'h0010_0000;
      repeat (12) @(posedge sys_clk);
      wr(4'h0, {14'h0, k[1:0]});
      wr(4'h5, {8'h0, fn});
      wr(4'h6, {15'h0, lg});
      d = k[4] ? 32'h0000_1387 : 32'h0000_031F;
      position_command <= k[2] ? 16'h0005 : 16'h0000;
      filtered_command <= k[3] ? 16'h0007 : 16'h0000;
      position_reference <= $urandom_range(1) ? base + d : base - d;
      repeat (10) @(posedge sys_clk);
      z = k[1:0] == 2'h0 || (k[1:0] == 2'h1 ? !k[2] : !k[3]);
      ec = z && !k[4];
      en = z;
      rd(4'h7, {13'h0, ((fn == 8'h86) ? ec : en) ^ lg, en, ec});
    end
    $display("Test mode table done");
    wr(4'h0, 16'h0000);
    wr(4'h5, 16'h0086);
    wr(4'h6, 16'h0000);
    {position_command, filtered_command} <= '0;
    position_reference <= base + 32'h0000_031F;
    repeat (10) @(posedge sys_clk);
    wr(4'h1, 16'h02BC);
    repeat (8) @(posedge sys_clk);
    rd(4'h7, 16'h0002);
    wr(4'h1, 16'h0320);
    rd(4'h7, 16'h0002);
    repeat (10) @(posedge sys_clk);
    rd(4'h7, 16'h0007);
    chk({15'h0, toggles != 8'h00}, 16'h0001);
    $display("Test live rewrite done");
    // Longer hold, condition lost at once: completed must outlast it
    wr(4'h4, 16'h0005);
    position_reference <= base + 32'h0010_0000;
    rd(4'h7, 16'h0005);
    repeat (10) @(posedge sys_clk);
    rd(4'h7, 16'h0000);
    // Unknown function code is invalid, so logic 1 turns the transistor on
    wr(4'h5, 16'h0083);
    wr(4'h6, 16'h0001);
    repeat (2) @(posedge sys_clk);
    rd(4'h7, 16'h0004);
    $display("Test hold and invalid code done");
    for (k = 0; k < 20 && exp_q.size() > 0; k++)
      @(posedge sys_clk);
    if (exp_q.size() != 0)
    begin
      $display("[ERR] %0t read results missing", $time);
      miscompares++;
    end
    wrap_up();
  end
endmodule : position_complete_output_tb
`default_nettype wire
